// >>> iarp_pkg.sv
package iarp_pkg;
   // Register map, one aligned 32-bit word each
   localparam int ADDR_W = 8;
   localparam logic [7:0] OFS_GENERAL = 8'h00;
   localparam logic [7:0] OFS_MEAS_CFG = 8'h04;
   localparam logic [7:0] OFS_INPUT_CFG = 8'h08;
   localparam logic [7:0] OFS_RESULT = 8'h0C;

   // Field positions
   localparam int PWM_EN_BIT = 0;
   localparam int MEAS_EN_BIT = 0;
   localparam int RANGE_LOW_LSB = 8;
   localparam int RANGE_HIGH_LSB = 16;
   localparam int INPUT_SEL_BIT = 0;
   localparam int EXC_LSB = 1;
   localparam int EXC_W = 3;

   // Writable bits and reset values
   localparam logic [31:0] GENERAL_MASK = 32'h0000_0001;
   localparam logic [31:0] MEAS_CFG_MASK = 32'h00FF_FF01;
   localparam logic [31:0] INPUT_CFG_MASK = 32'h0000_000F;
   localparam logic [31:0] GENERAL_RST = 32'h0000_0000;
   localparam logic [31:0] MEAS_CFG_RST = 32'h00FF_0000;
   localparam logic [31:0] INPUT_CFG_RST = 32'h0000_0000;
   localparam logic [2:0] EXC_OFF = 3'h0;

   // Converter
   localparam int CODE_W = 8;
   localparam int CODE_STEPS = 256;
   localparam int CODE_FULL = 255;
   localparam logic [7:0] RESULT_ALL_ONES = 8'hFF;
   localparam int SAMPLE_W = 12;
   localparam int RANGE_SHIFT = 4;
   localparam int FIFO_DEPTH = 4;

   // Timing
   localparam int CLK_HZ = 10_000_000;
   localparam int CONV_PERIOD_US = 100;
   localparam int CONV_CYC = CLK_HZ / 1_000_000 * CONV_PERIOD_US;
   localparam int STALE_US = 500;
   localparam int STALE_CYC = CLK_HZ / 1_000_000 * STALE_US;
   localparam int PWM_FREQ_HZ = 10_000;
   localparam int PWM_CYC = CLK_HZ / PWM_FREQ_HZ;
   localparam int DUTY_MIN_PCT = 10;
   localparam int DUTY_MAX_PCT = 90;

   // AXI responses
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   typedef enum logic [1:0] {
      IARP_PWM_OFF,
      IARP_PWM_HIGH,
      IARP_PWM_RUN
   } iarp_pwm_mode_t;
endpackage : iarp_pkg

// >>> iarp_fifo.sv
`timescale 1ns/1ps
module iarp_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   input wire logic aclk, // Clock
   input wire logic aresetn, // Synchronous reset, active low
   input wire logic in_valid, // Word offered
   output logic in_ready, // Room for a word
   input wire logic [WIDTH-1:0] in_data, // Word in
   output logic out_valid, // Word available
   input wire logic out_ready, // Drain side takes word
   output logic [WIDTH-1:0] out_data // Oldest word
);
   localparam int IW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
      $error("iarp_fifo: DEPTH must be a power of two, at least 2");
   end

   logic [WIDTH-1:0] mem [DEPTH];
   logic [IW-1:0] wr_ptr;
   logic [IW-1:0] rd_ptr;
   logic [IW:0] count;
   logic push;
   logic pop;

   assign in_ready = (count != (IW+1)'(DEPTH));
   assign out_valid = (count != '0);
   assign out_data = mem[rd_ptr];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_ff @(posedge aclk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         if (push) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
         if (push && !pop) begin
            count <= count + 1'b1;
         end else if (pop && !push) begin
            count <= count - 1'b1;
         end
      end
   end
endmodule : iarp_fifo

// >>> iarp_meas.sv
// Behaviour
// - Acquire and convert only while measurement enable is set.
// - 8-bit code spreads the low..high range over 256 equal steps.
// - Select 0 converts the differential pins; select 1 the temperature sensor.
// - Excitation current on positive pin chosen by a field; zero turns it off.
// - Latest result kept in a result register readable by the host.
// - Result reads all ones while measurement is disabled.
// - Result holds the most recent conversion while measurement is enabled.
// - Result reads all ones after about 500 us without a new result.
// - Output pin low while PWM enable is low; enable resets low.
// - Both enables high: 10 kHz PWM, duty min plus span times code/255.
// - Code zero gives minimum duty, all ones gives maximum duty.
// - Duty updates each time a new result is stored.
// - Stale result holds pin high until a new result arrives.
// - PWM enabled with measurement disabled holds pin high.
// - PWM output disabled while its enable is low, the reset default.
// - 8-bit conversions started at a fixed, unprogrammable period.
`timescale 1ns/1ps
module iarp_meas
   import iarp_pkg::*;
#(
   parameter int STALE_CYCLES = STALE_CYC,
   parameter int CONV_CYCLES = CONV_CYC,
   parameter int PWM_CYCLES = PWM_CYC,
   parameter int BUF_DEPTH = FIFO_DEPTH
) (
   input wire logic aclk, // Clock, 10 MHz
   input wire logic aresetn, // Synchronous reset, active low
   input wire logic [ADDR_W-1:0] s_axi_awaddr, // Write address
   input wire logic s_axi_awvalid, // Write address valid
   output logic s_axi_awready, // Write address ready
   input wire logic [31:0] s_axi_wdata, // Write data
   input wire logic [3:0] s_axi_wstrb, // Write byte lanes
   input wire logic s_axi_wvalid, // Write data valid
   output logic s_axi_wready, // Write data ready
   output logic [1:0] s_axi_bresp, // Write response
   output logic s_axi_bvalid, // Write response valid
   input wire logic s_axi_bready, // Write response ready
   input wire logic [ADDR_W-1:0] s_axi_araddr, // Read address
   input wire logic s_axi_arvalid, // Read address valid
   output logic s_axi_arready, // Read address ready
   output logic [31:0] s_axi_rdata, // Read data
   output logic [1:0] s_axi_rresp, // Read response
   output logic s_axi_rvalid, // Read data valid
   input wire logic s_axi_rready, // Read data ready
   input wire logic [SAMPLE_W-1:0] meas_in_diff, // Digitised meas_in_pos minus meas_in_neg
   input wire logic [SAMPLE_W-1:0] temp_sense_level, // Digitised internal temperature sensor
   output logic meas_active, // Converter front end powered
   output logic meas_input_sel, // Converter input mux select
   output logic [EXC_W-1:0] excitation_current_sel, // Current source on meas_in_pos
   output logic meas_pwm_out // Duty-modulated result pin
);
   if (STALE_CYCLES < 2 || STALE_CYCLES > 65535 || CONV_CYCLES < 2 || CONV_CYCLES > 65535 ||
       PWM_CYCLES < 2 || PWM_CYCLES > 65535) begin : g_bad_count
      $error("iarp_meas: counts must lie in 2..65535");
   end

   // Merge a write into a register image, honouring byte lanes and writable bits
   function automatic logic [31:0] apply_write(input logic [31:0] old, input logic [31:0] data,
                                               input logic [3:0] strb, input logic [31:0] mask);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[i*8 +: 8] = data[i*8 +: 8];
         end
      end
      return res & mask;
   endfunction : apply_write

   function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
      return (a == OFS_GENERAL) || (a == OFS_MEAS_CFG) || (a == OFS_INPUT_CFG) || (a == OFS_RESULT);
   endfunction : is_mapped

   // Quantise a sample against the programmed window
   function automatic logic [CODE_W-1:0] quantise(input logic [SAMPLE_W-1:0] v,
                                                  input logic [7:0] lo8, input logic [7:0] hi8);
      logic [SAMPLE_W-1:0] lo;
      logic [SAMPLE_W-1:0] hi;
      logic [31:0] q;
      lo = SAMPLE_W'({lo8, RANGE_SHIFT'(0)});
      hi = SAMPLE_W'({hi8, RANGE_SHIFT'(0)});
      q = 32'(CODE_FULL);
      if (hi <= lo || v <= lo) begin
         q = 32'd0;
      end else if (v < hi) begin
         q = (32'(v - lo) * 32'(CODE_STEPS)) / 32'(hi - lo);
         if (q > 32'(CODE_FULL)) begin
            q = 32'(CODE_FULL);
         end
      end
      return q[CODE_W-1:0];
   endfunction : quantise

   logic [31:0] general_config_reg;
   logic [31:0] meas_config_reg;
   logic [31:0] meas_input_config_reg;
   logic [CODE_W-1:0] meas_result_reg;
   logic pwm_en;
   logic meas_en;
   logic stale;
   logic [15:0] conv_cnt;
   logic conv_due;
   logic [15:0] stale_cnt;
   logic [15:0] pwm_cnt;
   logic [15:0] duty_high;
   logic [ADDR_W-1:0] aw_addr;
   logic aw_held;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic w_held;
   logic buf_in_ready;
   logic buf_out_valid;
   logic buf_out_ready;
   logic [CODE_W-1:0] buf_out_data;
   logic [CODE_W-1:0] next_code;
   logic store;
   logic [31:0] next_duty;

   assign pwm_en = general_config_reg[PWM_EN_BIT];
   assign meas_en = meas_config_reg[MEAS_EN_BIT];
   assign meas_active = meas_config_reg[MEAS_EN_BIT];
   assign meas_input_sel = meas_input_config_reg[INPUT_SEL_BIT];
   assign excitation_current_sel = meas_input_config_reg[EXC_LSB +: EXC_W];

   // Write channel: address and data are taken in either order, answered once both are in
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         aw_addr <= '0;
         s_axi_awready <= 1'b1;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held <= 1'b1;
         aw_addr <= s_axi_awaddr;
         s_axi_awready <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
         aw_held <= 1'b0;
         s_axi_awready <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held <= 1'b0;
         w_data <= '0;
         w_strb <= '0;
         s_axi_wready <= 1'b1;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held <= 1'b1;
         w_data <= s_axi_wdata;
         w_strb <= s_axi_wstrb;
         s_axi_wready <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
         w_held <= 1'b0;
         s_axi_wready <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else if (aw_held && w_held && !s_axi_bvalid) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= is_mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Configuration registers; the result word ignores writes
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         general_config_reg <= GENERAL_RST;
         meas_config_reg <= MEAS_CFG_RST;
         meas_input_config_reg <= INPUT_CFG_RST;
      end else if (aw_held && w_held && !s_axi_bvalid) begin
         case (aw_addr)
            OFS_GENERAL: general_config_reg <= apply_write(general_config_reg, w_data, w_strb, GENERAL_MASK);
            OFS_MEAS_CFG: meas_config_reg <= apply_write(meas_config_reg, w_data, w_strb, MEAS_CFG_MASK);
            OFS_INPUT_CFG: begin
               meas_input_config_reg <= apply_write(meas_input_config_reg, w_data, w_strb, INPUT_CFG_MASK);
            end
            default: begin
            end
         endcase
      end
   end

   // Read channel; while a read is pending the buffer is not drained so the word stays coherent
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
         case (s_axi_araddr)
            OFS_GENERAL: s_axi_rdata <= general_config_reg;
            OFS_MEAS_CFG: s_axi_rdata <= meas_config_reg;
            OFS_INPUT_CFG: s_axi_rdata <= meas_input_config_reg;
            OFS_RESULT: begin
               if (!meas_en || stale) begin
                  s_axi_rdata <= {24'h000000, RESULT_ALL_ONES};
               end else begin
                  s_axi_rdata <= {24'h000000, meas_result_reg};
               end
            end
            default: s_axi_rdata <= '0;
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // Fixed conversion period; a start that finds the buffer full waits for room
   always_ff @(posedge aclk) begin
      if (!aresetn || !meas_en) begin
         conv_cnt <= '0;
         conv_due <= 1'b0;
      end else begin
         if (conv_cnt == 16'(CONV_CYCLES - 1)) begin
            conv_cnt <= '0;
         end else begin
            conv_cnt <= conv_cnt + 16'h0001;
         end
         if (conv_cnt == 16'(CONV_CYCLES - 1)) begin
            conv_due <= 1'b1;
         end else if (buf_in_ready) begin
            conv_due <= 1'b0;
         end
      end
   end

   always_comb begin
      if (meas_input_sel) begin
         next_code = quantise(temp_sense_level, meas_config_reg[RANGE_LOW_LSB +: 8],
                              meas_config_reg[RANGE_HIGH_LSB +: 8]);
      end else begin
         next_code = quantise(meas_in_diff, meas_config_reg[RANGE_LOW_LSB +: 8],
                              meas_config_reg[RANGE_HIGH_LSB +: 8]);
      end
   end

   // Sampling keeps its fixed period while a read holds the result; up to four codes wait here
   iarp_fifo #(
      .WIDTH(CODE_W),
      .DEPTH(BUF_DEPTH)
   ) u_result_buf (
      .aclk(aclk),
      .aresetn(aresetn && meas_en),
      .in_valid(conv_due),
      .in_ready(buf_in_ready),
      .in_data(next_code),
      .out_valid(buf_out_valid),
      .out_ready(buf_out_ready),
      .out_data(buf_out_data)
   );

   assign buf_out_ready = !s_axi_rvalid;
   assign store = buf_out_valid && buf_out_ready;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meas_result_reg <= RESULT_ALL_ONES;
      end else if (store) begin
         meas_result_reg <= buf_out_data;
      end
   end

   // Staleness timer; also stale from enable until the first result
   always_ff @(posedge aclk) begin
      if (!aresetn || !meas_en) begin
         stale_cnt <= '0;
         stale <= 1'b1;
      end else if (store) begin
         stale_cnt <= '0;
         stale <= 1'b0;
      end else if (stale_cnt == 16'(STALE_CYCLES - 1)) begin
         stale <= 1'b1;
      end else begin
         stale_cnt <= stale_cnt + 16'h0001;
      end
   end

   // High time = min + span * code / 255, in clock cycles
   assign next_duty = (32'(PWM_CYCLES) * 32'(DUTY_MIN_PCT)) / 32'd100
                      + ((32'(PWM_CYCLES) * 32'(DUTY_MAX_PCT - DUTY_MIN_PCT)) / 32'd100)
                        * 32'(buf_out_data) / 32'(CODE_FULL);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         duty_high <= '0;
      end else if (store) begin
         duty_high <= next_duty[15:0];
      end
   end

   // Free-running period; a new high time takes effect at once, so the period in which
   // a store lands may show a blend of the old and the new duty
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pwm_cnt <= '0;
      end else if (pwm_cnt == 16'(PWM_CYCLES - 1)) begin
         pwm_cnt <= '0;
      end else begin
         pwm_cnt <= pwm_cnt + 16'h0001;
      end
   end

   iarp_pwm_mode_t pwm_mode;

   // Fallback levels outrank the running wave: off first, then forced high, then duty
   always_comb begin
      if (!pwm_en) begin
         pwm_mode = IARP_PWM_OFF;
      end else if (!meas_en || stale) begin
         pwm_mode = IARP_PWM_HIGH;
      end else begin
         pwm_mode = IARP_PWM_RUN;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meas_pwm_out <= 1'b0;
      end else begin
         case (pwm_mode)
            IARP_PWM_OFF: meas_pwm_out <= 1'b0;
            IARP_PWM_HIGH: meas_pwm_out <= 1'b1;
            IARP_PWM_RUN: meas_pwm_out <= (pwm_cnt < duty_high);
            default: meas_pwm_out <= 1'b0;
         endcase
      end
   end
endmodule : iarp_meas

// >>> iarp_meas_assertions.sv
`timescale 1ns/1ps
module iarp_meas_checker
   import iarp_pkg::*;
(
   input wire logic aclk, // Clock
   input wire logic aresetn, // Reset, low
   input wire logic [ADDR_W-1:0] s_axi_awaddr, // Write address
   input wire logic s_axi_awvalid, // Address valid
   input wire logic s_axi_awready, // Address ready
   input wire logic [31:0] s_axi_wdata, // Write data
   input wire logic [3:0] s_axi_wstrb, // Lanes
   input wire logic s_axi_wvalid, // Data valid
   input wire logic s_axi_wready, // Data ready
   input wire logic [1:0] s_axi_bresp, // Write response
   input wire logic s_axi_bvalid, // Response valid
   input wire logic s_axi_bready, // Response ready
   input wire logic [ADDR_W-1:0] s_axi_araddr, // Read address
   input wire logic s_axi_arvalid, // Read valid
   input wire logic s_axi_arready, // Read ready
   input wire logic [31:0] s_axi_rdata, // Read data
   input wire logic [1:0] s_axi_rresp, // Read response
   input wire logic s_axi_rvalid, // Data valid
   input wire logic s_axi_rready, // Data ready
   input wire logic meas_active, // Measure enable
   input wire logic meas_input_sel, // Input select
   input wire logic [EXC_W-1:0] excitation_current_sel, // Current source
   input wire logic meas_pwm_out // Pin
);
   logic [ADDR_W-1:0] wr_addr;
   logic [ADDR_W-1:0] rd_addr;
   logic [31:0] wr_data;
   logic [3:0] wr_strb;
   logic pwm_en_m;
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   always_ff @(posedge aclk) begin
      if (s_axi_awvalid && s_axi_awready) wr_addr <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready) wr_data <= s_axi_wdata;
      if (s_axi_wvalid && s_axi_wready) wr_strb <= s_axi_wstrb;
      if (s_axi_arvalid && s_axi_arready) rd_addr <= s_axi_araddr;
   end
   // Mirror of the PWM enable; lags the register until the response is taken
   always_ff @(posedge aclk) begin
      if (!aresetn) pwm_en_m <= 1'b0;
      else if (s_axi_bvalid && s_axi_bready && s_axi_bresp == RESP_OKAY && wr_addr == OFS_GENERAL && wr_strb[0])
         pwm_en_m <= wr_data[PWM_EN_BIT];
   end
   sequence s_rd_take;
      s_axi_arvalid && s_axi_arready;
   endsequence
   sequence s_rd_answer;
      s_axi_rvalid && !s_axi_arready;
   endsequence
   AST_PWM_LOW: assert property (!pwm_en_m [*3] |-> !meas_pwm_out)
      else $error("pin high while pwm disabled");
   AST_FORCED_HIGH: assert property ((pwm_en_m && !meas_active) [*3] |-> meas_pwm_out)
      else $error("pin low while measuring off");
   AST_ENABLE_STALE: assert property ($rose(meas_active) && pwm_en_m |-> meas_pwm_out [*8])
      else $error("pin not high before first result");
   AST_ACTIVE_FOLLOWS: assert property ($rose(s_axi_bvalid) && wr_addr == OFS_MEAS_CFG && wr_strb[0]
      |-> meas_active == wr_data[MEAS_EN_BIT]) else $error("measure enable not applied");
   AST_SEL_FOLLOWS: assert property ($rose(s_axi_bvalid) && wr_addr == OFS_INPUT_CFG && wr_strb[0]
      |-> meas_input_sel == wr_data[INPUT_SEL_BIT] && excitation_current_sel == wr_data[EXC_LSB +: EXC_W])
      else $error("input setup not applied");
   AST_RESULT_OFF: assert property ($rose(s_axi_rvalid) && rd_addr == OFS_RESULT && !meas_active
      |-> s_axi_rdata == 32'h0000_00FF) else $error("result not all ones when off");
   AST_RD_ANSWER: assert property (s_rd_take |=> s_rd_answer)
      else $error("read answer late");
   AST_RD_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   AST_RD_REFUSE: assert property ($rose(s_axi_rvalid) && rd_addr > OFS_RESULT
      |-> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read accepted");
endmodule : iarp_meas_checker
bind iarp_meas iarp_meas_checker u_chk (.*);

// >>> iarp_pwm_meter.sv
`timescale 1ns/1ps
module iarp_pwm_meter #(
   parameter int WIN = 1000
) (
   input wire logic aclk, // Clock
   input wire logic pin, // Pin read by host
   output int high_cnt, // High cycles of last window
   output logic win_done // Window closed
);
   // Any full window of a periodic wave gives its duty, so no phase lock is needed
   int pos = 0;
   int cnt = 0;
   // The window flag starts unknown and settles low at the first edge; waiters test for a solid 1
   always_ff @(posedge aclk) begin
      win_done <= (pos == WIN - 1);
      pos <= (pos == WIN - 1) ? 0 : pos + 1;
      cnt <= (pos == WIN - 1) ? 0 : cnt + int'(pin === 1'b1);
      if (pos == WIN - 1) high_cnt <= cnt + int'(pin === 1'b1);
   end
endmodule : iarp_pwm_meter

// >>> iarp_meas_tb.sv
`timescale 1ns/1ps
module iarp_meas_tb;
   import iarp_pkg::*;
   logic aclk = 0;
   logic aresetn = 0;
   logic [7:0] awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, rdata;
   logic [3:0] wstrb = 0;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic awready, wready, bvalid, arready, rvalid, active, sel, pin, win_done;
   logic [1:0] bresp, rresp;
   logic [11:0] diff = 0, temp = 0;
   logic [2:0] exc;
   logic [31:0] regs [4] = '{GENERAL_RST, MEAS_CFG_RST, INPUT_CFG_RST, 32'hFF};
   logic [31:0] msk [3] = '{GENERAL_MASK, MEAS_CFG_MASK, INPUT_CFG_MASK};
   int n_fail = 0, checks_done = 0, cyc = 0, seed = 69574, hi_cnt;

   iarp_meas #(.STALE_CYCLES(50), .CONV_CYCLES(10), .PWM_CYCLES(PWM_CYC)) uut (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .meas_in_diff(diff), .temp_sense_level(temp), .meas_active(active),
      .meas_input_sel(sel), .excitation_current_sel(exc), .meas_pwm_out(pin));
   iarp_pwm_meter #(.WIN(PWM_CYC)) u_host (.aclk(aclk), .pin(pin), .high_cnt(hi_cnt), .win_done(win_done));

   initial forever #50 aclk = ~aclk;
   always @(posedge aclk) begin
      cyc++;
      if (cyc > 60000) begin
         n_fail++;
         results();
      end
   end

   task automatic results();
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : results

   task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic chk_duty(string what, int exp, int got);
      checks_done++;
      if (got != exp) begin
         n_fail++;
         $display("[FAIL] %s expected %0d seen %0d", what, exp, got);
      end
   endtask : chk_duty

   // Clamped like the converter: below the range reads 0, above it 255
   function automatic int code(int v, int lo, int hi);
      int q;
      if (hi <= lo || v <= lo * 16) return 0;
      q = (v - lo * 16) * CODE_STEPS / ((hi - lo) * 16);
      return (q > CODE_FULL) ? CODE_FULL : q;
   endfunction : code

   task automatic wr(logic [7:0] a, logic [31:0] d, logic [3:0] s);
      logic [31:0] lm;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      bready <= 1'b0;
      chk("bresp", 32'((a < 8'h10) ? RESP_OKAY : RESP_SLVERR), 32'(bresp));
      for (int i = 0; i < 4; i++) lm[8*i +: 8] = {8{s[i]}};
      if (a < OFS_RESULT) regs[a[3:2]] = (regs[a[3:2]] & ~(lm & msk[a[3:2]])) | (d & lm & msk[a[3:2]]);
   endtask : wr

   task automatic rd(logic [7:0] a, int hold, output logic [31:0] d);
      int n;
      n = 0;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= (hold == 0);
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
         n++;
         if (n >= hold && rready !== 1'b1) rready <= 1'b1;
      end while (!(rvalid === 1'b1 && rready === 1'b1));
      d = rdata;
      rready <= 1'b0;
      chk("rresp", 32'((a < 8'h10) ? RESP_OKAY : RESP_SLVERR), 32'(rresp));
   endtask : rd

   task automatic duty_of(output int h);
      repeat (2) begin
         @(posedge aclk);
         while (win_done !== 1'b1) @(posedge aclk);
      end
      h = hi_cnt;
   endtask : duty_of

   task automatic out_ok(int c);
      logic [31:0] d;
      int h, e;
      e = PWM_CYC * DUTY_MIN_PCT / 100 + PWM_CYC * (DUTY_MAX_PCT - DUTY_MIN_PCT) / 100 * c / CODE_FULL;
      rd(OFS_RESULT, 0, d);
      chk("result", 32'(c), d);
      duty_of(h);
      chk_duty("duty", e, h);
   endtask : out_ok

   initial begin
      logic [31:0] d;
      logic [7:0] lo, hi, a;
      logic [11:0] dv, tv;
      int c, h;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      wr(OFS_RESULT, 32'h0, 4'hF);
      wr(8'h10, 32'hFFFF_FFFF, 4'hF);
      for (int i = 0; i < 5; i++) begin
         rd(8'(i * 4), 0, d);
         chk("reset read", (i < 4) ? regs[i] : 32'h0, d);
      end
      for (int i = 0; i < 8; i++) begin
         a = 8'(($unsigned($random(seed)) % 3) * 4);
         wr(a, $random(seed), 4'($random(seed)));
         rd(a, 0, d);
         chk("reg readback", regs[a[3:2]], d);
      end
      wr(OFS_MEAS_CFG, 32'h0, 4'hF);
      wr(OFS_GENERAL, 32'h0, 4'hF);
      duty_of(h);
      chk_duty("pwm off", 0, h);
      wr(OFS_GENERAL, 32'h1, 4'hF);
      duty_of(h);
      chk_duty("pwm forced", PWM_CYC, h);
      for (int i = 0; i < 8; i++) begin
         dv = 12'($random(seed));
         tv = 12'($random(seed));
         if (i < 2) dv = 12'h000;
         if (i < 2) tv = 12'hFFF;
         lo = 8'($random(seed)) & 8'h7F;
         hi = lo + 8'd1 + (8'($random(seed)) & 8'h7F);
         diff <= dv;
         temp <= tv;
         wr(OFS_INPUT_CFG, {28'h0, 3'(i), 1'(i)}, 4'hF);
         wr(OFS_MEAS_CFG, {8'h0, hi, lo, 8'h01}, 4'hF);
         rd(OFS_RESULT, 0, d);
         chk("first result", 32'hFF, d);
         chk("pins", {27'h0, active, sel, exc}, {27'h0, 1'b1, 1'(i), 3'(i)});
         c = code(i[0] ? tv : dv, lo, hi);
         repeat (40) @(posedge aclk);
         out_ok(c);
         if (i == 2) begin
            // A held read response blocks the result store, so the result goes stale
            fork
               rd(OFS_RESULT, 300, d);
               begin
                  repeat (70) @(posedge aclk);
                  h = 0;
                  repeat (200) begin
                     @(posedge aclk);
                     h += int'(pin === 1'b1);
                  end
               end
            join
            chk("stalled read", 32'(c), d);
            chk_duty("stale pin", 200, h);
            dv = ~dv;
            tv = ~tv;
            diff <= dv;
            temp <= tv;
            c = code(i[0] ? tv : dv, lo, hi);
            repeat (40) @(posedge aclk);
            out_ok(c);
         end
         wr(OFS_MEAS_CFG, 32'h0, 4'hF);
         rd(OFS_RESULT, 0, d);
         chk("result off", 32'hFF, d);
      end
      results();
   end
endmodule : iarp_meas_tb
